// ==== core/rft_params.svh ====
// constants for the rail fault and thermal flag bank
`ifndef RFT_PARAMS_SVH
`define RFT_PARAMS_SVH
// ==========================================
// offsets
`define RFT_OFS_RAIL_A 8'hB2
`define RFT_OFS_RAIL_B 8'hB3
`define RFT_OFS_THERM 8'hB5
// ==========================================
// implemented bit masks and reset values
`define RFT_MASK_RAIL_A 8'hBF
`define RFT_MASK_RAIL_B 8'h19
`define RFT_MASK_THERM 8'h1F
`define RFT_RESET_VAL 8'h00
// ==========================================
// field positions
`define RFT_BIT_LINEAR_A2 7
`define RFT_BIT_LINEAR_A1 4
`define RFT_BIT_TERM_REG 3
`define RFT_BIT_LINEAR_A3 0
`define RFT_BIT_DIE_HOT 4
`define RFT_BIT_TERM_HOT 3
`define RFT_BIT_TOP_RIGHT 2
`define RFT_BIT_TOP_LEFT 1
`define RFT_BIT_BOT_RIGHT 0
`endif

// ==== core/rft_pkg.sv ====
// types for the rail fault and thermal flag bank
package rft_pkg;
    // register port request from the serial bus logic
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rft_req_t;
    // raw fault levels from the analog detectors
    typedef struct packed {
        logic       linear_a2;
        logic [5:0] step_down;
        logic       linear_a1;
        logic       term_reg;
        logic       linear_a3;
        logic [4:0] hot;
    } rft_evt_t;
endpackage

// ==== core/rft_flag_reg.sv ====
// one sticky flag register: set on event, cleared by writing one
`timescale 1ns/1ps
`include "rft_params.svh"
module rft_flag_reg #(
    parameter logic [7:0] MASK = 8'hFF
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // control
    input wire logic [7:0] set_i,
    input wire logic clr_we_i,
    input wire logic [7:0] clr_data_i,
    // state
    output logic [7:0] flags_o
);
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;

    // set wins over a clear in the same cycle; reserved bits forced low
    always_comb begin
        flags_nxt = flags_r;
        if (clr_we_i) begin
            flags_nxt = flags_nxt & ~clr_data_i;
        end
        flags_nxt = (flags_nxt | set_i) & MASK;
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            flags_r <= `RFT_RESET_VAL;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_o = flags_r;

    property p_sticky;
        @(posedge mclk_i) disable iff (reset_i)
        (flags_r != 8'h00) && !clr_we_i |=> ((flags_r & $past(flags_r)) == $past(flags_r));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without clear");

    property p_clear;
        @(posedge mclk_i) disable iff (reset_i)
        clr_we_i && (set_i == 8'h00) |=> ((flags_r & $past(clr_data_i)) == 8'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear");

    property p_set;
        @(posedge mclk_i) disable iff (reset_i)
        1'b1 |=> ((flags_r & ($past(set_i) & MASK)) == ($past(set_i) & MASK));
    endproperty
    a_set: assert property (p_set) else $error("event not latched");

    property p_resv;
        @(posedge mclk_i) disable iff (reset_i)
        1'b1 |-> ((flags_r & ~MASK) == 8'h00);
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set");
endmodule

// ==== core/rft_flags.sv ====
// rail fault and thermal warning sticky flag bank
`timescale 1ns/1ps
`include "rft_params.svh"
module rft_flags
    import rft_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // register port
    input wire rft_req_t req_i,
    output logic [7:0] rdata_o,
    // fault detector levels, asynchronous to mclk_i
    input wire rft_evt_t evt_i,
    // flag state
    output logic [7:0] rail_fault_flags_a_o,
    output logic [7:0] rail_fault_flags_b_o,
    output logic [7:0] thermal_warning_flags_o
);
    // ==========================================
    // synchronisers: three stages, change counts when 2 and 3 agree
    localparam int EW = $bits(rft_evt_t);
    logic [EW-1:0] s1_r, s2_r, s3_r, filt_r;
    logic [EW-1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;
    rft_evt_t ev;

    always_comb begin
        s1_nxt = evt_i;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        filt_nxt = filt_r;
        for (int i = 0; i < EW; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                filt_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            filt_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            filt_r <= filt_nxt;
        end
    end

    assign ev = rft_evt_t'(filt_r);

    // ==========================================
    // set vectors; level-held faults keep setting, so the flag recurs after clear
    logic [7:0] set_a, set_b, set_t;
    always_comb begin
        set_a = 8'h00;
        set_a[`RFT_BIT_LINEAR_A2] = ev.linear_a2;
        set_a[5:0] = ev.step_down;
        set_b = 8'h00;
        set_b[`RFT_BIT_LINEAR_A1] = ev.linear_a1;
        set_b[`RFT_BIT_TERM_REG] = ev.term_reg;
        set_b[`RFT_BIT_LINEAR_A3] = ev.linear_a3;
        set_t = {3'h0, ev.hot};
    end

    // ==========================================
    // write decode
    logic we_a, we_b, we_t;
    assign we_a = req_i.wr && (req_i.addr == `RFT_OFS_RAIL_A);
    assign we_b = req_i.wr && (req_i.addr == `RFT_OFS_RAIL_B);
    assign we_t = req_i.wr && (req_i.addr == `RFT_OFS_THERM);

    logic [7:0] fa, fb, ft;
    rft_flag_reg #(.MASK(`RFT_MASK_RAIL_A)) u_rail_a (
        .mclk_i(mclk_i), .reset_i(reset_i), .set_i(set_a),
        .clr_we_i(we_a), .clr_data_i(req_i.wdata), .flags_o(fa)
    );
    rft_flag_reg #(.MASK(`RFT_MASK_RAIL_B)) u_rail_b (
        .mclk_i(mclk_i), .reset_i(reset_i), .set_i(set_b),
        .clr_we_i(we_b), .clr_data_i(req_i.wdata), .flags_o(fb)
    );
    rft_flag_reg #(.MASK(`RFT_MASK_THERM)) u_therm (
        .mclk_i(mclk_i), .reset_i(reset_i), .set_i(set_t),
        .clr_we_i(we_t), .clr_data_i(req_i.wdata), .flags_o(ft)
    );

    // ==========================================
    // registered read data and flag outputs; unmapped reads give zero
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] oa_r, ob_r, ot_r;

    always_comb begin
        rdata_nxt = rdata_r;
        if (req_i.rd) begin
            unique case (req_i.addr)
                `RFT_OFS_RAIL_A: rdata_nxt = fa;
                `RFT_OFS_RAIL_B: rdata_nxt = fb;
                `RFT_OFS_THERM: rdata_nxt = ft;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_r <= `RFT_RESET_VAL;
            oa_r <= `RFT_RESET_VAL;
            ob_r <= `RFT_RESET_VAL;
            ot_r <= `RFT_RESET_VAL;
        end else begin
            rdata_r <= rdata_nxt;
            oa_r <= fa;
            ob_r <= fb;
            ot_r <= ft;
        end
    end

    assign rdata_o = rdata_r;
    assign rail_fault_flags_a_o = oa_r;
    assign rail_fault_flags_b_o = ob_r;
    assign thermal_warning_flags_o = ot_r;

    // ==========================================
    sequence s_hot_seen;
        ev.hot[0] ##1 1'b1;
    endsequence
    property p_hot_flag;
        @(posedge mclk_i) disable iff (reset_i)
        s_hot_seen |-> ft[`RFT_BIT_BOT_RIGHT];
    endproperty
    a_hot_flag: assert property (p_hot_flag) else $error("hot flag not set");

    property p_term_map;
        @(posedge mclk_i) disable iff (reset_i)
        ev.term_reg |=> fb[`RFT_BIT_TERM_REG];
    endproperty
    a_term_map: assert property (p_term_map) else $error("term fault misplaced");

    property p_therm_resv;
        @(posedge mclk_i) disable iff (reset_i)
        req_i.rd && (req_i.addr == `RFT_OFS_THERM) |=> (rdata_o[7:5] == 3'h0);
    endproperty
    a_therm_resv: assert property (p_therm_resv) else $error("reserved read nonzero");

    property p_read_a;
        @(posedge mclk_i) disable iff (reset_i)
        req_i.rd && (req_i.addr == `RFT_OFS_RAIL_A) |=> (rdata_o == $past(fa));
    endproperty
    a_read_a: assert property (p_read_a) else $error("rail a read wrong");

    property p_a2_hold;
        @(posedge mclk_i) disable iff (reset_i)
        fa[`RFT_BIT_LINEAR_A2] && !we_a |=> fa[`RFT_BIT_LINEAR_A2];
    endproperty
    a_a2_hold: assert property (p_a2_hold) else $error("a2 flag dropped");

    property p_therm_clear;
        @(posedge mclk_i) disable iff (reset_i)
        we_t && req_i.wdata[`RFT_BIT_DIE_HOT] && !ev.hot[4] |=> !ft[`RFT_BIT_DIE_HOT];
    endproperty
    a_therm_clear: assert property (p_therm_clear) else $error("die hot not cleared");

    property p_read_b;
        @(posedge mclk_i) disable iff (reset_i)
        req_i.rd && (req_i.addr == `RFT_OFS_RAIL_B) |=> (rdata_o == $past(fb));
    endproperty
    a_read_b: assert property (p_read_b) else $error("rail b read wrong");

    property p_read_t;
        @(posedge mclk_i) disable iff (reset_i)
        req_i.rd && (req_i.addr == `RFT_OFS_THERM) |=> (rdata_o == $past(ft));
    endproperty
    a_read_t: assert property (p_read_t) else $error("thermal read wrong");

    // unmapped offsets read as zero so a host scan never sees stale data
    property p_read_none;
        @(posedge mclk_i) disable iff (reset_i)
        req_i.rd && (req_i.addr != `RFT_OFS_RAIL_A) && (req_i.addr != `RFT_OFS_RAIL_B)
            && (req_i.addr != `RFT_OFS_THERM) |=> (rdata_o == 8'h00);
    endproperty
    a_read_none: assert property (p_read_none) else $error("unmapped read nonzero");

    // flag outputs trail the internal registers by exactly one cycle
    property p_out_a;
        @(posedge mclk_i) disable iff (reset_i)
        1'b1 |=> (rail_fault_flags_a_o == $past(fa));
    endproperty
    a_out_a: assert property (p_out_a) else $error("rail a output stale");

    property p_out_b;
        @(posedge mclk_i) disable iff (reset_i)
        1'b1 |=> (rail_fault_flags_b_o == $past(fb));
    endproperty
    a_out_b: assert property (p_out_b) else $error("rail b output stale");

    property p_out_t;
        @(posedge mclk_i) disable iff (reset_i)
        1'b1 |=> (thermal_warning_flags_o == $past(ft));
    endproperty
    a_out_t: assert property (p_out_t) else $error("thermal output stale");

    property p_step_map;
        @(posedge mclk_i) disable iff (reset_i)
        (ev.step_down != 6'h00) |=> ((fa[5:0] & $past(ev.step_down)) == $past(ev.step_down));
    endproperty
    a_step_map: assert property (p_step_map) else $error("step-down fault misplaced");

    property p_a2_map;
        @(posedge mclk_i) disable iff (reset_i)
        ev.linear_a2 |=> fa[`RFT_BIT_LINEAR_A2];
    endproperty
    a_a2_map: assert property (p_a2_map) else $error("a2 fault misplaced");

    property p_a1_map;
        @(posedge mclk_i) disable iff (reset_i)
        ev.linear_a1 |=> fb[`RFT_BIT_LINEAR_A1];
    endproperty
    a_a1_map: assert property (p_a1_map) else $error("a1 fault misplaced");

    property p_a3_map;
        @(posedge mclk_i) disable iff (reset_i)
        ev.linear_a3 |=> fb[`RFT_BIT_LINEAR_A3];
    endproperty
    a_a3_map: assert property (p_a3_map) else $error("a3 fault misplaced");

    property p_therm_map;
        @(posedge mclk_i) disable iff (reset_i)
        (ev.hot != 5'h00) |=> ((ft[4:0] & $past(ev.hot)) == $past(ev.hot));
    endproperty
    a_therm_map: assert property (p_therm_map) else $error("zone flag misplaced");

    // a still-active fault would re-set the flag, so only a quiet rail must clear
    property p_rail_clear;
        @(posedge mclk_i) disable iff (reset_i)
        we_a && req_i.wdata[`RFT_BIT_LINEAR_A2] && !ev.linear_a2 |=> !fa[`RFT_BIT_LINEAR_A2];
    endproperty
    a_rail_clear: assert property (p_rail_clear) else $error("a2 flag not cleared");

    property p_keep_b;
        @(posedge mclk_i) disable iff (reset_i)
        we_b |=> ((fb & $past(fb & ~req_i.wdata)) == $past(fb & ~req_i.wdata));
    endproperty
    a_keep_b: assert property (p_keep_b) else $error("rail b zero write cleared");

    property p_keep_t;
        @(posedge mclk_i) disable iff (reset_i)
        we_t |=> ((ft & $past(ft & ~req_i.wdata)) == $past(ft & ~req_i.wdata));
    endproperty
    a_keep_t: assert property (p_keep_t) else $error("thermal zero write cleared");
endmodule

// ==== sim/rft_host_model.sv ====
// host controller model driving the flag bank register port
`timescale 1ns/1ps
module rft_host_model
    import rft_pkg::*;
(
    // clock
    input wire logic mclk_i,
    // register port
    output rft_req_t req_o,
    input wire logic [7:0] rdata_i
);
    // ==========================================
    // access tasks, driven on the falling edge
    initial req_o = '0;
    // an idle port shows the inverted address so a stale address never looks valid; wdata is inverted on each release, so a read restores the last written data
    task automatic release_port();
        req_o.wr = 1'b0;
        req_o.rd = 1'b0;
        req_o.addr = ~req_o.addr;
        req_o.wdata = ~req_o.wdata;
    endtask
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge mclk_i);
        req_o.wr = 1'b1;
        req_o.addr = addr;
        req_o.wdata = data;
        @(negedge mclk_i);
        release_port();
    endtask
    task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge mclk_i);
        req_o.rd = 1'b1;
        req_o.addr = addr;
        @(negedge mclk_i);
        release_port();
        @(negedge mclk_i);
        data = rdata_i;
    endtask
endmodule

// ==== sim/tb_rail_fault_thermal_flags.sv ====
// self-checking bench for the sticky flag bank
`timescale 1ns/1ps
`include "rft_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH at %0t got %h exp %h", $time, g, e); end end
module tb_rail_fault_thermal_flags
    import rft_pkg::*;
;
    logic mclk_i;
    logic reset_i;
    rft_req_t req;
    logic [7:0] rdata;
    logic [$bits(rft_evt_t)-1:0] evt_v;
    wire logic [7:0] flg [3];
    logic [7:0] ofs [3] = '{`RFT_OFS_RAIL_A, `RFT_OFS_RAIL_B, `RFT_OFS_THERM};
    logic [7:0] ex [3];
    logic [7:0] d;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int j;
    int b;
    // ==========================================
    // instances
    rft_flags i_rft_flags (.mclk_i(mclk_i), .reset_i(reset_i), .req_i(req), .rdata_o(rdata),
        .evt_i(rft_evt_t'(evt_v)), .rail_fault_flags_a_o(flg[0]),
        .rail_fault_flags_b_o(flg[1]), .thermal_warning_flags_o(flg[2]));
    rft_host_model i_rft_host_model (.mclk_i(mclk_i), .req_o(req), .rdata_i(rdata));
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    // ==========================================
    // helpers
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk_all();
        for (int k = 0; k < 3; k++) begin
            i_rft_host_model.rd_reg(ofs[k], d);
            `CHK(d, ex[k])
            `CHK(flg[k], ex[k])
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // ==========================================
    // scenarios
    initial begin
        evt_v = '0;
        reset_i = 1'b1;
        ex = '{8'h00, 8'h00, 8'h00};
        wait_cyc(10);
        reset_i = 1'b0;
        chk_all();
        for (int i = 0; i < $bits(rft_evt_t); i++) begin
            j = (i < 5) ? 2 : (i < 8) ? 1 : 0;
            b = (i < 5) ? i : (i == 5) ? `RFT_BIT_LINEAR_A3 : (i == 6) ? `RFT_BIT_TERM_REG :
                (i == 7) ? `RFT_BIT_LINEAR_A1 : (i < 14) ? i - 8 : `RFT_BIT_LINEAR_A2;
            evt_v[i] = 1'b1;
            wait_cyc(10);
            evt_v[i] = 1'b0;
            wait_cyc(10);
            ex[j] = 8'h01 << b;
            chk_all();
            i_rft_host_model.wr_reg(ofs[j], ~ex[j]);
            wait_cyc(3);
            chk_all();
            i_rft_host_model.wr_reg(ofs[j], ex[j]);
            ex[j] = 8'h00;
            wait_cyc(3);
            chk_all();
        end
        evt_v = '1;
        wait_cyc(10);
        ex = '{`RFT_MASK_RAIL_A, `RFT_MASK_RAIL_B, `RFT_MASK_THERM};
        chk_all();
        for (int k = 0; k < 3; k++)
            i_rft_host_model.wr_reg(ofs[k], 8'hFF);
        wait_cyc(3);
        chk_all();
        evt_v = '0;
        i_rft_host_model.wr_reg(8'hB4, 8'hFF);
        wait_cyc(10);
        chk_all();
        i_rft_host_model.rd_reg(8'hB4, d);
        `CHK(d, 8'h00)
        for (int k = 0; k < 3; k++)
            i_rft_host_model.wr_reg(ofs[k], 8'hFF);
        ex = '{8'h00, 8'h00, 8'h00};
        wait_cyc(3);
        chk_all();
        // second reset with every flag set: all of them must drop to zero
        evt_v = '1;
        wait_cyc(10);
        reset_i = 1'b1;
        evt_v = '0;
        wait_cyc(2);
        reset_i = 1'b0;
        chk_all();
        end_of_test();
    end
endmodule
